/* File: hw/cbtb_cond_eval.sv */
// Purpose: Evaluates a 4-bit condition code against the NZCV flags
// Assumes: Flags packed N,Z,C,V from bit 3 down
// Notes: Purely combinational
`timescale 1ns/1ps
`include "cbtb_params.svh"
module cbtb_cond_eval (
  input wire logic [3:0] cond,
  input wire logic [3:0] flags,
  output logic pass
);
  logic n, z, c, v, base;
  always_comb begin
    n = flags[`CBTB_FLAG_N];
    z = flags[`CBTB_FLAG_Z];
    c = flags[`CBTB_FLAG_C];
    v = flags[`CBTB_FLAG_V];
    case (cond[3:1])
      3'h0: base = z;
      3'h1: base = c;
      3'h2: base = n;
      3'h3: base = v;
      3'h4: base = c & ~z;
      3'h5: base = (n == v);
      3'h6: base = (n == v) & ~z;
      default: base = 1'b1;
    endcase
    if (cond[3:1] == 3'h7) begin
      pass = 1'b1;
    end else begin
      pass = base ^ cond[0];
    end
  end
endmodule

/* File: hw/cbtb_params.svh */
// Purpose: Constants for the conditional-block and table-branch sequencer
// Assumes: Included by its bare name
// Notes: Condition codes follow the usual 4-bit encoding
`ifndef CBTB_PARAMS_SVH
`define CBTB_PARAMS_SVH
`define CBTB_MAX_BLOCK 3'h4
`define CBTB_COND_UNCOND 4'hE
`define CBTB_PC_ADV 32'h0000_0004
`define CBTB_REG_SP 4'hD
`define CBTB_REG_PC 4'hF
`define CBTB_FLAG_N 3
`define CBTB_FLAG_Z 2
`define CBTB_FLAG_C 1
`define CBTB_FLAG_V 0
`endif

/* File: hw/cbtb_pkg.sv */
// Purpose: Types for the conditional-block and table-branch sequencer
// Assumes: Nothing
// Notes: Operation classes come from the upstream decoder
package cbtb_pkg;
  typedef enum logic [3:0] {
    CBTB_OP_OTHER, CBTB_OP_PREFIX, CBTB_OP_CMPBR_Z, CBTB_OP_CMPBR_NZ, CBTB_OP_TBL_BYTE,
    CBTB_OP_TBL_HALF, CBTB_OP_BREAK, CBTB_OP_FLAGSET, CBTB_OP_EXC_RET
  } cbtb_op_t;
  typedef enum logic [1:0] {CBTB_IDLE, CBTB_TBL_WAIT} cbtb_state_t;
endpackage

/* File: hw/cbtb_seq.sv */
// Purpose: Conditional-block state, table-branch target and flag keeping
// Assumes: Decoder presents one instruction per issue pulse with operands
// Notes: Condition flags owned here; exec unit offers updates via flag_wr
`timescale 1ns/1ps
`include "cbtb_params.svh"
module cbtb_seq (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic issue,
  input cbtb_pkg::cbtb_op_t op,
  input wire logic [3:0] instr_cond,
  input wire logic [7:0] prefix_bits,
  input wire logic [31:0] pc,
  input wire logic [3:0] base_reg,
  input wire logic [31:0] base_val,
  input wire logic [31:0] index_val,
  input wire logic [7:0] ret_state,
  input wire logic exc_take,
  input wire logic flag_wr,
  input wire logic [3:0] flag_in,
  input wire logic tbl_valid,
  input wire logic [15:0] tbl_data,
  output logic exec_en,
  output logic in_block,
  output logic [7:0] saved_state,
  output logic [3:0] flags,
  output logic tbl_req,
  output logic tbl_half,
  output logic [31:0] tbl_addr,
  output logic br_valid,
  output logic [31:0] br_target,
  output logic busy
);
  typedef struct packed {
    cbtb_pkg::cbtb_state_t st;
    logic [3:0] cond;
    logic [4:0] mask;
    logic [3:0] flags;
    logic [7:0] saved;
    logic tbl_req;
    logic tbl_half;
    logic [31:0] tbl_addr;
    logic [31:0] next_pc;
    logic br_valid;
    logic [31:0] br_target;
    logic exec_en;
  } cbtb_st_t;

  cbtb_st_t s_q;
  cbtb_st_t s_d;
  logic [3:0] applied_cond;
  logic cond_pass;
  logic flags_locked;

  function automatic logic [31:0] cbtb_fwd(input logic [31:0] from, input logic [15:0] ent);
    cbtb_fwd = from + {15'h0000, ent, 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Condition applied to the current instruction
  always_comb begin
    if (s_q.mask[3:0] != 4'h0) begin
      applied_cond = {s_q.cond[3:1], s_q.mask[4]};
    end else begin
      applied_cond = instr_cond;
    end
  end

  cbtb_cond_eval u_eval (
    .cond(applied_cond),
    .flags(s_q.flags),
    .pass(cond_pass)
  );

  assign flags_locked = (op == cbtb_pkg::CBTB_OP_CMPBR_Z) ||
    (op == cbtb_pkg::CBTB_OP_CMPBR_NZ) ||
    (op == cbtb_pkg::CBTB_OP_PREFIX) || (op == cbtb_pkg::CBTB_OP_TBL_BYTE) ||
    (op == cbtb_pkg::CBTB_OP_TBL_HALF);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.br_valid = 1'b0;
    s_d.tbl_req = 1'b0;
    s_d.exec_en = 1'b0;
    case (s_q.st)
      cbtb_pkg::CBTB_IDLE: begin
        if (exc_take) begin
          s_d.saved = {s_q.cond[3:1], s_q.mask};
          // Handler runs outside any block until the return restores it
          s_d.cond = 4'h0;
          s_d.mask = 5'h00;
        end else if (issue) begin
          s_d.exec_en = cond_pass || (op == cbtb_pkg::CBTB_OP_BREAK);
          if (op == cbtb_pkg::CBTB_OP_EXC_RET) begin
            s_d.cond = {ret_state[7:5], ret_state[4]};
            s_d.mask = ret_state[4:0];
            s_d.exec_en = 1'b1;
          end else if (op == cbtb_pkg::CBTB_OP_PREFIX) begin
            s_d.cond = prefix_bits[7:4];
            s_d.mask = {prefix_bits[4], prefix_bits[3:0]};
            s_d.exec_en = 1'b1;
          end else begin
            if (s_q.mask[2:0] == 3'h0) begin
              s_d.mask = 5'h00;
            end else begin
              s_d.mask = {s_q.mask[3:0], 1'b0};
            end
            if (cond_pass && ((op == cbtb_pkg::CBTB_OP_TBL_BYTE) ||
                (op == cbtb_pkg::CBTB_OP_TBL_HALF))) begin
              s_d.tbl_half = (op == cbtb_pkg::CBTB_OP_TBL_HALF);
              s_d.next_pc = pc + `CBTB_PC_ADV;
              if (base_reg == `CBTB_REG_PC) begin
                s_d.tbl_addr = pc + `CBTB_PC_ADV;
              end else begin
                s_d.tbl_addr = base_val;
              end
              if (op == cbtb_pkg::CBTB_OP_TBL_HALF) begin
                s_d.tbl_addr = s_d.tbl_addr + {index_val[30:0], 1'b0};
              end else begin
                s_d.tbl_addr = s_d.tbl_addr + index_val;
              end
              s_d.tbl_req = 1'b1;
              s_d.st = cbtb_pkg::CBTB_TBL_WAIT;
            end
          end
          if (flag_wr && cond_pass && !flags_locked) begin
            s_d.flags = flag_in;
          end
        end
      end
      cbtb_pkg::CBTB_TBL_WAIT: begin
        s_d.tbl_req = !tbl_valid;
        if (tbl_valid) begin
          if (s_q.tbl_half) begin
            s_d.br_target = cbtb_fwd(s_q.next_pc, tbl_data);
          end else begin
            s_d.br_target = cbtb_fwd(s_q.next_pc, {8'h00, tbl_data[7:0]});
          end
          s_d.br_valid = 1'b1;
          s_d.st = cbtb_pkg::CBTB_IDLE;
        end
      end
      default: s_d.st = cbtb_pkg::CBTB_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign exec_en = s_q.exec_en;
  assign in_block = (s_q.mask[3:0] != 4'h0);
  assign saved_state = s_q.saved;
  assign flags = s_q.flags;
  assign tbl_req = s_q.tbl_req;
  assign tbl_half = s_q.tbl_half;
  assign tbl_addr = s_q.tbl_addr;
  assign br_valid = s_q.br_valid;
  assign br_target = s_q.br_target;
  assign busy = (s_q.st != cbtb_pkg::CBTB_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_cmpbr_flags;
    @(posedge mclk) disable iff (!nrst)
      (issue && !exc_take && s_q.st == cbtb_pkg::CBTB_IDLE &&
       (op == cbtb_pkg::CBTB_OP_CMPBR_Z || op == cbtb_pkg::CBTB_OP_CMPBR_NZ)) |=>
        $stable(flags);
  endproperty
  a_cmpbr_flags: assert property (p_cmpbr_flags) else $error("compare branch flags");

  property p_prefix_flags;
    @(posedge mclk) disable iff (!nrst)
      (issue && !exc_take && s_q.st == cbtb_pkg::CBTB_IDLE &&
       op == cbtb_pkg::CBTB_OP_PREFIX) |=> $stable(flags) && in_block;
  endproperty
  a_prefix_flags: assert property (p_prefix_flags) else $error("prefix bad");

  sequence s_tb_issue;
    issue && !exc_take && s_q.st == cbtb_pkg::CBTB_IDLE && cond_pass &&
      (op == cbtb_pkg::CBTB_OP_TBL_BYTE || op == cbtb_pkg::CBTB_OP_TBL_HALF);
  endsequence
  property p_tb_flags;
    @(posedge mclk) disable iff (!nrst) s_tb_issue |=> $stable(flags) && tbl_req;
  endproperty
  a_tb_flags: assert property (p_tb_flags) else $error("table branch flags");

  property p_tb_target;
    @(posedge mclk) disable iff (!nrst)
      (busy && tbl_valid && tbl_half) |=>
        br_valid && br_target == $past(s_q.next_pc) + {15'h0000, $past(tbl_data), 1'b0};
  endproperty
  a_tb_target: assert property (p_tb_target) else $error("bad target");

  property p_pc_base;
    @(posedge mclk) disable iff (!nrst)
      (s_tb_issue and (base_reg == `CBTB_REG_PC && op == cbtb_pkg::CBTB_OP_TBL_BYTE)) |=>
        tbl_addr == $past(pc) + `CBTB_PC_ADV + $past(index_val);
  endproperty
  a_pc_base: assert property (p_pc_base) else $error("pc base");

  property p_half_idx;
    @(posedge mclk) disable iff (!nrst)
      (s_tb_issue and (base_reg != `CBTB_REG_PC && op == cbtb_pkg::CBTB_OP_TBL_HALF)) |=>
        tbl_addr == $past(base_val) + {$past(index_val[30:0]), 1'b0};
  endproperty
  a_half_idx: assert property (p_half_idx) else $error("half index");

  property p_break;
    @(posedge mclk) disable iff (!nrst)
      (issue && !exc_take && !busy && op == cbtb_pkg::CBTB_OP_BREAK) |=> exec_en;
  endproperty
  a_break: assert property (p_break) else $error("breakpoint skipped");

  property p_save;
    @(posedge mclk) disable iff (!nrst)
      (exc_take && !busy) |=> saved_state == {$past(s_q.cond[3:1]), $past(s_q.mask)};
  endproperty
  a_save: assert property (p_save) else $error("state not saved");

  property p_restore;
    @(posedge mclk) disable iff (!nrst)
      (issue && !exc_take && !busy && op == cbtb_pkg::CBTB_OP_EXC_RET) |=>
        s_q.mask == $past(ret_state[4:0]);
  endproperty
  a_restore: assert property (p_restore) else $error("not restored");

  property p_advance;
    @(posedge mclk) disable iff (!nrst)
      (issue && !exc_take && !busy && in_block && op == cbtb_pkg::CBTB_OP_OTHER &&
       s_q.mask[2:0] == 3'h0) |=> !in_block;
  endproperty
  a_advance: assert property (p_advance) else $error("block not ended");

  // Equal-family block: a slot with mask[4] clear follows Z, one with mask[4] set its inverse
  property p_cond;
    @(posedge mclk) disable iff (!nrst)
      (issue && !exc_take && !busy && in_block && op == cbtb_pkg::CBTB_OP_OTHER &&
       s_q.cond[3:1] == 3'h0) |=>
        exec_en == ($past(flags[`CBTB_FLAG_Z]) ^ $past(s_q.mask[4]));
  endproperty
  a_cond: assert property (p_cond) else $error("applied cond");

  property p_exc_clear;
    @(posedge mclk) disable iff (!nrst)
      (exc_take && !busy) |=> !in_block;
  endproperty
  a_exc_clear: assert property (p_exc_clear) else $error("block kept in handler");

  property p_tbb_target;
    @(posedge mclk) disable iff (!nrst)
      (busy && tbl_valid && !tbl_half) |=>
        br_valid && br_target == $past(s_q.next_pc) + {23'h00_0000, $past(tbl_data[7:0]), 1'b0};
  endproperty
  a_tbb_target: assert property (p_tbb_target) else $error("bad byte target");

  property p_next_pc;
    @(posedge mclk) disable iff (!nrst)
      s_tb_issue |=> s_q.next_pc == $past(pc) + `CBTB_PC_ADV;
  endproperty
  a_next_pc: assert property (p_next_pc) else $error("next address");

  property p_byte_idx;
    @(posedge mclk) disable iff (!nrst)
      (s_tb_issue and (base_reg != `CBTB_REG_PC && op == cbtb_pkg::CBTB_OP_TBL_BYTE)) |=>
        tbl_addr == $past(base_val) + $past(index_val);
  endproperty
  a_byte_idx: assert property (p_byte_idx) else $error("byte index");

  property p_req_hold;
    @(posedge mclk) disable iff (!nrst)
      (busy && !tbl_valid) |=> tbl_req && busy;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("table request dropped");

  // Issue during a table fetch is ignored and leaves the flags alone
  property p_busy_refuse;
    @(posedge mclk) disable iff (!nrst)
      (busy && issue) |=> !exec_en && $stable(flags);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("issue taken while busy");

  property p_flag_upd;
    @(posedge mclk) disable iff (!nrst)
      (issue && !exc_take && !busy && flag_wr && cond_pass &&
       op == cbtb_pkg::CBTB_OP_OTHER) |=> flags == $past(flag_in);
  endproperty
  a_flag_upd: assert property (p_flag_upd) else $error("flag update lost");
endmodule

/* File: tb/cbtb_seq_bench.sv */
// Purpose: Self-checking bench for the block sequencer and table branch
// Assumes: Inputs driven at falling edge; outputs sampled at the next falling edge
// Notes: Expected values worked out by hand from the condition encoding
`timescale 1ns/1ps
module cbtb_seq_bench;
  logic mclk, nrst, issue, exc_take, flag_wr, tbl_valid;
  cbtb_pkg::cbtb_op_t op;
  logic [3:0] instr_cond, base_reg, flag_in, flags;
  logic [7:0] prefix_bits, ret_state, saved_state;
  logic [31:0] pc, base_val, index_val, tbl_addr, br_target;
  logic [15:0] tbl_data;
  logic exec_en, in_block, tbl_req, tbl_half, br_valid, busy, ex;
  int err_count, check_count;

  cbtb_seq cbtb_seq_inst (.mclk(mclk), .nrst(nrst), .issue(issue), .op(op),
    .instr_cond(instr_cond), .prefix_bits(prefix_bits), .pc(pc), .base_reg(base_reg),
    .base_val(base_val), .index_val(index_val), .ret_state(ret_state),
    .exc_take(exc_take), .flag_wr(flag_wr), .flag_in(flag_in), .tbl_valid(tbl_valid),
    .tbl_data(tbl_data), .exec_en(exec_en), .in_block(in_block),
    .saved_state(saved_state), .flags(flags), .tbl_req(tbl_req), .tbl_half(tbl_half),
    .tbl_addr(tbl_addr), .br_valid(br_valid), .br_target(br_target), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic issue_op(input cbtb_pkg::cbtb_op_t o, input logic [3:0] c,
      input logic [7:0] pb, input logic fw, input logic [3:0] fi);
    @(negedge mclk);
    issue = 1'b1;
    op = o;
    instr_cond = c;
    prefix_bits = pb;
    flag_wr = fw;
    flag_in = fi;
    @(negedge mclk);
    issue = 1'b0;
    flag_wr = 1'b0;
    ex = exec_en;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_flags;
    issue_op(cbtb_pkg::CBTB_OP_OTHER, 4'hE, 8'h00, 1'b1, 4'h4);
    chk(ex, 1'b1);
    chk(flags, 4'h4);
    issue_op(cbtb_pkg::CBTB_OP_CMPBR_Z, 4'hE, 8'h00, 1'b1, 4'hB);
    chk(flags, 4'h4);
    issue_op(cbtb_pkg::CBTB_OP_CMPBR_NZ, 4'hE, 8'h00, 1'b1, 4'hB);
    chk(flags, 4'h4);
  endtask

  // Four-deep then-then-else-else block on equal, Z set, exception mid-block
  task automatic t_block;
    issue_op(cbtb_pkg::CBTB_OP_PREFIX, 4'hE, 8'h07, 1'b1, 4'hF);
    chk(flags, 4'h4);
    chk(in_block, 1'b1);
    issue_op(cbtb_pkg::CBTB_OP_OTHER, 4'h0, 8'h00, 1'b0, 4'h0);
    chk(ex, 1'b1);
    @(negedge mclk);
    exc_take = 1'b1;
    @(negedge mclk);
    exc_take = 1'b0;
    chk(saved_state, 8'h0E);
    chk(in_block, 1'b0);
    ret_state = 8'h0E;
    issue_op(cbtb_pkg::CBTB_OP_EXC_RET, 4'hE, 8'h00, 1'b0, 4'h0);
    chk(in_block, 1'b1);
    issue_op(cbtb_pkg::CBTB_OP_OTHER, 4'h0, 8'h00, 1'b0, 4'h0);
    chk(ex, 1'b1);
    issue_op(cbtb_pkg::CBTB_OP_OTHER, 4'h1, 8'h00, 1'b1, 4'h0);
    chk(ex, 1'b0);
    chk(flags, 4'h4);
    chk(in_block, 1'b1);
    issue_op(cbtb_pkg::CBTB_OP_OTHER, 4'h1, 8'h00, 1'b0, 4'h0);
    chk(ex, 1'b0);
    chk(in_block, 1'b0);
  endtask

  // Single not-equal block holding a breakpoint whose condition fails
  task automatic t_break;
    issue_op(cbtb_pkg::CBTB_OP_PREFIX, 4'hE, 8'h18, 1'b0, 4'h0);
    issue_op(cbtb_pkg::CBTB_OP_BREAK, 4'h1, 8'h00, 1'b0, 4'h0);
    chk(ex, 1'b1);
    chk(in_block, 1'b0);
  endtask

  // Unconditional-code block of one instruction: always executes
  task automatic t_always;
    issue_op(cbtb_pkg::CBTB_OP_PREFIX, 4'hE, 8'hE8, 1'b0, 4'h0);
    chk(in_block, 1'b1);
    issue_op(cbtb_pkg::CBTB_OP_OTHER, 4'hE, 8'h00, 1'b1, 4'h6);
    chk(ex, 1'b1);
    chk(flags, 4'h6);
    chk(in_block, 1'b0);
  endtask

  task automatic t_table(input cbtb_pkg::cbtb_op_t o, input logic [3:0] br,
      input logic [31:0] bv, input logic [31:0] p, input logic [31:0] idx,
      input logic [15:0] d, input logic [31:0] ea, input logic eh, input logic [31:0] et);
    int n;
    pc = p;
    base_reg = br;
    base_val = bv;
    index_val = idx;
    issue_op(o, 4'hE, 8'h00, 1'b1, 4'hF);
    n = 0;
    while (tbl_req !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    if (n == 8) begin
      err_count++;
      end_of_test();
    end
    chk(tbl_addr, ea);
    chk(tbl_half, eh);
    issue_op(cbtb_pkg::CBTB_OP_OTHER, 4'hE, 8'h00, 1'b0, 4'h0);
    chk(ex, 1'b0);
    chk(busy, 1'b1);
    tbl_valid = 1'b1;
    tbl_data = d;
    @(negedge mclk);
    tbl_valid = 1'b0;
    tbl_data = 16'h5A5A;
    chk(br_valid, 1'b1);
    chk(br_target, et);
    chk(busy, 1'b0);
    chk(flags, 4'h4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    end_of_test();
  end

  initial begin
    {nrst, issue, exc_take, flag_wr, tbl_valid} = 5'h00;
    op = cbtb_pkg::CBTB_OP_OTHER;
    {instr_cond, base_reg, flag_in} = 12'h000;
    {prefix_bits, ret_state} = 16'h0000;
    {pc, base_val, index_val} = 96'h0;
    tbl_data = 16'h0000;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    chk({flags, in_block, busy, tbl_req, br_valid}, 32'h0000_0000);
    chk(saved_state, 8'h00);
    t_flags();
    t_block();
    t_break();
    t_table(cbtb_pkg::CBTB_OP_TBL_HALF, 4'hF, 32'h0000_0000, 32'h0000_1000, 32'h0000_0003,
      16'hFFFF, 32'h0000_100A, 1'b1, 32'h0002_1002);
    t_table(cbtb_pkg::CBTB_OP_TBL_BYTE, 4'h0, 32'h0000_2000, 32'h0000_3000, 32'h0000_0005,
      16'hABCD, 32'h0000_2005, 1'b0, 32'h0000_319E);
    t_table(cbtb_pkg::CBTB_OP_TBL_BYTE, 4'hF, 32'h0000_0000, 32'h0000_4000, 32'h0000_0002,
      16'h0010, 32'h0000_4006, 1'b0, 32'h0000_4024);
    t_table(cbtb_pkg::CBTB_OP_TBL_HALF, 4'h1, 32'h0000_5000, 32'h0000_6000, 32'h0000_0004,
      16'h0100, 32'h0000_5008, 1'b1, 32'h0000_6204);
    t_always();
    end_of_test();
  end
endmodule
